//--- bst_defines.svh
// Constants of the boundary scan test access port
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH

`define BST_IR_W 4
`define BST_IR_CAPTURE 4'h1
`define BST_IR_RESET 4'hf
`define BST_IR_EXTEST 4'h0
`define BST_IR_SAMPLE 4'h1
`define BST_IR_BYPASS 4'hf
`define BST_PINS 8
`define BST_BYPASS_CAPTURE 1'h0

`endif

//--- bst_pkg.sv
// Types of the boundary scan test access port
`default_nettype none
package bst_pkg;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bst_state_e;

  // Test pins as seen after synchronisation
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } bst_pins_s;

endpackage : bst_pkg
`default_nettype wire

//--- bst_tap.sv
// Boundary scan test access port with controller, instruction, boundary and bypass registers
`timescale 1ns/1ps
`default_nettype none
`include "bst_defines.svh"

// Summary of operation
// [RULE1] Sixteen-state controller including reset, idle, capture/shift/update
// [RULE2] Mode select sampled on rising test clock
// [RULE3] Test data input captured on rising edge
// [RULE4] Output driven only in shift states, falling edge
// [RULE5] Test reset forces test-logic-reset asynchronously
// [RULE6] Instruction register selects boundary or bypass
// [RULE7] Boundary chain holds one cell per pin
// [RULE8] All state changes except test reset follow test clock edges
// [RULE9] Bypass captures zero, one-stage delay
module bst_tap #(
  parameter int PINS = `BST_PINS
) (
  // System
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // Test pins
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oe_n_o,
  // Device pins
  input wire logic [PINS-1:0] pin_in_i,
  output logic [PINS-1:0] pin_out_o,
  output logic extest_o
);

  // ****************************************
  // Synchronisers
  // ****************************************
  bst_pkg::bst_pins_s meta_r, sync_r, meta_nxt, sync_nxt;
  logic tck_d_r, tck_d_nxt;
  logic rise, fall, trst_act;

  always_comb
  begin
    meta_nxt = '{tck: tck_i, tms: tms_i, tdi: tdi_i, trst_n: trst_n_i};
    sync_nxt = meta_r;
    tck_d_nxt = sync_r.tck;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
      sync_r <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
      tck_d_r <= 1'b0;
    end
    else if (en_i)
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      tck_d_r <= tck_d_nxt;
    end
  end

  // Edges of the sampled test clock; apart from test reset, nothing else moves the test logic
  assign rise = sync_r.tck & ~tck_d_r; // [RULE8]
  assign fall = ~sync_r.tck & tck_d_r; // [RULE8]
  // Test reset acts on its own, with no test clock edge needed; the
  // two-stage sampling adds a fixed latency of two system clocks
  assign trst_act = ~sync_r.trst_n; // [RULE5]

  // ****************************************
  // Controller and registers
  // ****************************************
  bst_pkg::bst_state_e state_r, state_nxt;
  logic [`BST_IR_W-1:0] ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
  logic [PINS-1:0] bs_sh_r, bs_sh_nxt, bs_upd_r, bs_upd_nxt;
  logic byp_r, byp_nxt;
  logic tdo_r, tdo_nxt, oe_n_r, oe_n_nxt;
  logic sel_bs;

  assign sel_bs = (ir_r != `BST_IR_BYPASS); // [RULE6]

  always_comb
  begin
    state_nxt = state_r;
    ir_sh_nxt = ir_sh_r;
    ir_nxt = ir_r;
    bs_sh_nxt = bs_sh_r;
    bs_upd_nxt = bs_upd_r;
    byp_nxt = byp_r;
    tdo_nxt = tdo_r;
    oe_n_nxt = oe_n_r;
    if (trst_act)
    begin
      state_nxt = bst_pkg::ST_RESET; // [RULE5]
      ir_nxt = `BST_IR_RESET;
      oe_n_nxt = 1'b1;
    end
    else if (rise)
    begin
      unique case (state_r) // [RULE1] [RULE2]
        bst_pkg::ST_RESET: state_nxt = sync_r.tms ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
        bst_pkg::ST_IDLE: state_nxt = sync_r.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
        bst_pkg::ST_SEL_DR: state_nxt = sync_r.tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
        bst_pkg::ST_CAP_DR: state_nxt = sync_r.tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
        bst_pkg::ST_SH_DR: state_nxt = sync_r.tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
        bst_pkg::ST_EX1_DR: state_nxt = sync_r.tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
        bst_pkg::ST_PAU_DR: state_nxt = sync_r.tms ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
        bst_pkg::ST_EX2_DR: state_nxt = sync_r.tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
        bst_pkg::ST_UPD_DR: state_nxt = sync_r.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
        bst_pkg::ST_SEL_IR: state_nxt = sync_r.tms ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
        bst_pkg::ST_CAP_IR: state_nxt = sync_r.tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
        bst_pkg::ST_SH_IR: state_nxt = sync_r.tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
        bst_pkg::ST_EX1_IR: state_nxt = sync_r.tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
        bst_pkg::ST_PAU_IR: state_nxt = sync_r.tms ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
        bst_pkg::ST_EX2_IR: state_nxt = sync_r.tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
        bst_pkg::ST_UPD_IR: state_nxt = sync_r.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      endcase
      unique case (state_r)
        bst_pkg::ST_RESET: ir_nxt = `BST_IR_RESET;
        bst_pkg::ST_CAP_IR: ir_sh_nxt = `BST_IR_CAPTURE;
        bst_pkg::ST_SH_IR: ir_sh_nxt = {sync_r.tdi, ir_sh_r[`BST_IR_W-1:1]}; // [RULE3]
        bst_pkg::ST_UPD_IR: ir_nxt = ir_sh_r;
        bst_pkg::ST_CAP_DR:
        begin
          if (sel_bs)
            bs_sh_nxt = pin_in_i; // [RULE7]
          else
            byp_nxt = `BST_BYPASS_CAPTURE; // [RULE9]
        end
        bst_pkg::ST_SH_DR:
        begin
          if (sel_bs)
            bs_sh_nxt = {sync_r.tdi, bs_sh_r[PINS-1:1]}; // [RULE3] [RULE7]
          else
            byp_nxt = sync_r.tdi; // [RULE9]
        end
        bst_pkg::ST_UPD_DR:
        begin
          if (sel_bs)
            bs_upd_nxt = bs_sh_r;
        end
        default:
        begin
        end
      endcase
    end
    else if (fall)
    begin
      // Output follows the state reached at the last rising edge
      if (state_r == bst_pkg::ST_SH_IR)
      begin
        tdo_nxt = ir_sh_r[0]; // [RULE4]
        oe_n_nxt = 1'b0;
      end
      else if (state_r == bst_pkg::ST_SH_DR)
      begin
        tdo_nxt = sel_bs ? bs_sh_r[0] : byp_r; // [RULE4] [RULE6]
        oe_n_nxt = 1'b0;
      end
      else
        oe_n_nxt = 1'b1; // [RULE4]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= bst_pkg::ST_RESET;
      ir_sh_r <= `BST_IR_RESET;
      ir_r <= `BST_IR_RESET;
      bs_sh_r <= '0;
      bs_upd_r <= '0;
      byp_r <= 1'b0;
      tdo_r <= 1'b0;
      oe_n_r <= 1'b1;
    end
    else if (en_i)
    begin
      state_r <= state_nxt;
      ir_sh_r <= ir_sh_nxt;
      ir_r <= ir_nxt;
      bs_sh_r <= bs_sh_nxt;
      bs_upd_r <= bs_upd_nxt;
      byp_r <= byp_nxt;
      tdo_r <= tdo_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic ext_r, ext_nxt;

  always_comb
  begin
    ext_nxt = (ir_r == `BST_IR_EXTEST);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ext_r <= 1'b0;
    else if (en_i)
      ext_r <= ext_nxt;
  end

  assign tdo_o = tdo_r;
  assign tdo_oe_n_o = oe_n_r;
  assign pin_out_o = bs_upd_r;
  assign extest_o = ext_r;

endmodule : bst_tap
`default_nettype wire

//--- bst_tap_chk_asserts.sv
// Checker of the boundary scan port outputs
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker
// ****
module bst_tap_chk #(parameter int PINS = 8) (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic tck_i,
  input wire logic trst_n_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_n_o,
  input wire logic [PINS-1:0] pin_out_o,
  input wire logic extest_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Test reset must outlast the synchroniser before it is judged
  sequence s_trst; !trst_n_i [*4]; endsequence
  property p_rst; $rose(rst_n_i) |-> tdo_oe_n_o && !extest_o && pin_out_o == '0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle");
  property p_trst; s_trst |=> tdo_oe_n_o && !extest_o; endproperty
  a_trst: assert property (p_trst) else $error("test reset ignored");
  property p_oe_on; $fell(tdo_oe_n_o) |-> !$past(tck_i, 3); endproperty
  a_oe_on: assert property (p_oe_on) else $error("enable not on fall");
  property p_oe_off; $rose(tdo_oe_n_o) |-> !$past(tck_i, 3) || !trst_n_i; endproperty
  a_oe_off: assert property (p_oe_off) else $error("release not on fall");
  property p_tdo; $changed(tdo_o) |-> !$past(tck_i, 3); endproperty
  a_tdo: assert property (p_tdo) else $error("data out not on fall");
  property p_en; !en_i |=> $stable({tdo_o, tdo_oe_n_o, pin_out_o, extest_o}); endproperty
  a_en: assert property (p_en) else $error("moved while frozen");
  property p_pin; $changed(pin_out_o) |-> $past(tdo_oe_n_o); endproperty
  a_pin: assert property (p_pin) else $error("latch moved in shift");
  property p_ext; $changed(extest_o) |-> $past(tdo_oe_n_o) || !trst_n_i; endproperty
  a_ext: assert property (p_ext) else $error("mode moved in shift");
endmodule : bst_tap_chk
bind bst_tap bst_tap_chk #(.PINS(PINS)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i), .tck_i(tck_i),
  .trst_n_i(trst_n_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o), .pin_out_o(pin_out_o), .extest_o(extest_o));
`default_nettype wire

//--- bst_tester.sv
// Model of the external boundary scan tester
`timescale 1ns/1ps
`default_nettype none
// ****
// Tester
// ****
module bst_tester (
  // Test pins
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_n_i
);
  // Clock idles low, mode and data sit at their pull-up level
  initial
  begin
    tck_o = 0;
    tms_o = 1;
    tdi_o = 1;
  end
  task automatic step(input logic m, input logic b, output logic q);
    tms_o = m;
    tdi_o = b;
    #200 q = tdo_oe_n_i ? 1'bz : tdo_i;
    tck_o = 1;
    #200 tck_o = 0;
  endtask : step
  task automatic init();
    logic q;
    #1;
    repeat (5) step(1, 1, q);
    step(0, 1, q);
  endtask : init
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1, 1, q);
    if (ir) step(1, 1, q);
    step(0, 1, q);
    step(0, 1, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1, 1, q);
    step(0, 1, q);
    tdi_o = 1;
  endtask : scan
endmodule : bst_tester
`default_nettype wire

//--- tb_boundary_scan_tap.sv
// Testbench of the boundary scan port
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module tb_boundary_scan_tap;
  logic clk_i = 0, rst_n_i = 0, en_i = 1, trst_n_i = 1, tck, tms, tdi, tdo, oe_n, ext, q;
  // Pin pattern is no bit palindrome, so a chain shifted the wrong way round shows up
  logic [7:0] pin_in = 8'h3a, pin_out;
  logic [31:0] d;
  int n_errors = 0, n_checks = 0, n_cyc = 0;
  bst_tap dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n_i), .tdo_o(tdo), .tdo_oe_n_o(oe_n), .pin_in_i(pin_in), .pin_out_o(pin_out), .extest_o(ext));
  bst_tester tester (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_n_i(oe_n));
  initial forever #25 clk_i = ~clk_i;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  always @(posedge clk_i)
  begin
    n_cyc++;
    if (n_cyc == 2000)
    begin
      n_errors++;
      end_sim();
    end
  end
  task t_reset();
    chk({oe_n, ext, pin_out}, 10'h200);
    tester.scan(0, 4, 4'hb, d);
    chk(d, 32'h6);
  endtask : t_reset
  task automatic t_codes();
    logic [3:0] c[3] = '{4'h0, 4'h1, 4'hf};
    foreach (c[i])
    begin
      tester.scan(1, 4, c[i], d);
      chk(d, 32'h1);
      chk(ext, c[i] == 0);
      tester.scan(0, 8, 8'hc3, d);
      chk(d, c[i] == 4'hf ? 32'h86 : 32'h3a);
    end
    chk(pin_out, 8'hc3);
  endtask : t_codes
  task t_trst();
    tester.scan(1, 4, 4'h0, d);
    tester.step(1, 1, q);
    tester.step(0, 1, q);
    tester.step(0, 1, q);
    repeat (5) @(posedge clk_i);
    chk(oe_n, 0);
    #1 en_i = 0;
    repeat (3) @(posedge clk_i);
    #1 en_i = 1;
    trst_n_i = 0;
    repeat (6) @(posedge clk_i);
    chk({oe_n, ext}, 2'h2);
    #1 trst_n_i = 1;
    repeat (4) @(posedge clk_i);
    tester.init();
  endtask : t_trst
  initial
  begin
    repeat (5) @(posedge clk_i);
    #1 rst_n_i = 1;
    repeat (5) @(posedge clk_i);
    tester.init();
    t_reset();
    t_codes();
    t_trst();
    end_sim();
  end
endmodule : tb_boundary_scan_tap
`default_nettype wire
